// [hw/io_ctrl_pkg.sv]
// constants, register map and encodings of the instrument i/o control block
// assumes a single 200 MHz clock and a plain strobe register port
// Operation
// - plc-only locks panel and remote keys
// - serial-only accepts serial, disables all keys
// - local plus plc accepts keys and plc
// - local default takes panel or remote keys
// - masses 2, 3, 4 amu, helium-4 default
// - mass change accepted only in standby
// - two recorder channels, seven functions each
// - mantissa output linear 1 to 10 volts
// - exponent staircase 0.5 volt per decade
// - linear leak rate 0 to 10 volts
// - logarithmic 1 to 10 volts, adjustable slope
// - baud 1200 to 19200, selectable line terminator
// - 7/8 data, parity, 1/2 stop bits
// - four selectable serial protocol variants
// - four changeover relays, independent function each
// - trigger relay open when exceeded or idle
// - zero-active relay closed while zeroing
// - ready relay closed when emission, no error
// - calibration-active relay closed during calibration
// - calibration-request relay opens on request
// - fault and warning relays open when shown
// - gas ballast closed; fixed open/closed functions
// - recorder strobe closed when leak output invalid
// - plc inputs only in plc locations
package io_ctrl_pkg;
    localparam int CLK_HZ = 200_000_000;

    // ====================================================
    // register map, byte addresses
    localparam logic [7:0] OFS_LOC    = 8'h00;
    localparam logic [7:0] OFS_MASS   = 8'h04;
    localparam logic [7:0] OFS_REC0   = 8'h08;
    localparam logic [7:0] OFS_REC1   = 8'h0c;
    localparam logic [7:0] OFS_SCALE  = 8'h10;
    localparam logic [7:0] OFS_SERIAL = 8'h14;
    localparam logic [7:0] OFS_RELAY  = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // ====================================================
    // encodings
    typedef enum logic [2:0] {
        LOC_PLC = 3'h0, LOC_SERIAL = 3'h1, LOC_LOCAL_PLC = 3'h2, LOC_LOCAL_SERIAL = 3'h3, LOC_LOCAL = 3'h4
    } loc_t;
    typedef enum logic [1:0] {MASS_H2 = 2'h0, MASS_HE3 = 2'h1, MASS_HE4 = 2'h2} mass_t;
    typedef enum logic [2:0] {
        REC_OFF = 3'h0, REC_INLET = 3'h1, REC_FORE = 3'h2, REC_MANT = 3'h3,
        REC_EXP = 3'h4, REC_LIN = 3'h5, REC_LOG = 3'h6
    } rec_func_t;
    typedef enum logic [3:0] {
        RLY_TRIG1 = 4'h0, RLY_TRIG2 = 4'h1, RLY_TRIG3 = 4'h2, RLY_ZERO = 4'h3, RLY_READY = 4'h4,
        RLY_CAL_ACT = 4'h5, RLY_CAL_REQ = 4'h6, RLY_FAIL = 4'h7, RLY_WARN = 4'h8, RLY_GAS = 4'h9,
        RLY_OPEN = 4'ha, RLY_CLOSE = 4'hb, RLY_STROBE = 4'hc
    } relay_func_t;

    // ====================================================
    // reset values and field positions
    localparam logic [2:0]  LOC_RST      = 3'h4;
    localparam logic [1:0]  MASS_RST     = 2'h2;
    localparam logic [2:0]  SCALE_RST    = 3'h1;
    localparam logic [3:0]  UPPER_RST    = 4'hb;
    localparam logic [11:0] SERIAL_RST   = 12'h003;
    localparam logic [15:0] RELAY_RST    = 16'ha4ba;
    localparam int          SER_BAUD_LSB = 0;
    localparam int          SER_TERM_LSB = 3;
    localparam int          SER_DATA8    = 5;
    localparam int          SER_PAR_LSB  = 6;
    localparam int          SER_STOP2    = 8;
    localparam int          SER_PROT_LSB = 9;
    localparam int          UPPER_LSB    = 8;
    localparam int          ST_REJECT    = 4;
    localparam int          ST_CAL_ADV   = 5;

    // ====================================================
    // recorder voltages in millivolts
    localparam int MV_FULL    = 10000;
    localparam int MV_ONE     = 1000;
    localparam int MV_EXP_STP = 500;
    localparam int EXP_BASE   = -12;
endpackage

// [hw/leak_detector_io_control.sv]
// control location arbiter, mass selection, recorder encoding and relay mapping
// assumes key, serial and status inputs are synchronous to ref_clk; plc pins are not
`timescale 1ns/1ps
`default_nettype none
module leak_detector_io_control #(
    parameter int REC_CH = 2,
    parameter int RELAYS = 4
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // register port
    input  wire logic [7:0]            addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  we,
    input  wire logic                  re,
    output logic      [31:0]           rdata,
    // command sources, one-cycle pulses; the plc pins carry levels that must last two cycles
    input  wire logic                  panel_start,
    input  wire logic                  panel_stop,
    input  wire logic                  panel_zero,
    input  wire logic                  remote_start,
    input  wire logic                  remote_stop,
    input  wire logic                  remote_zero,
    input  wire logic                  serial_start,
    input  wire logic                  serial_stop,
    input  wire logic                  serial_zero,
    input  wire logic [2:0]            plc_in,
    // arbitrated commands
    output logic                       cmd_start,
    output logic                       cmd_stop,
    output logic                       cmd_zero,
    // machine state
    input  wire logic                  in_standby,
    input  wire logic                  measuring,
    input  wire logic [2:0]            trig_exceeded,
    input  wire logic                  zero_running,
    input  wire logic                  emission_on,
    input  wire logic                  error_shown,
    input  wire logic                  warning_shown,
    input  wire logic                  cal_running,
    input  wire logic                  cal_requested,
    input  wire logic                  gas_ballast_on,
    // measured values
    input  wire logic [13:0]           inlet_pressure,
    input  wire logic [13:0]           forevacuum_pressure,
    input  wire logic [9:0]            lr_mant,
    input  wire logic signed [5:0]     lr_exp,
    input  wire logic                  lr_valid,
    // outputs
    output logic      [1:0]            mass_sel,
    output logic      [REC_CH*14-1:0]  rec_mv,
    output logic      [RELAYS-1:0]     relay_closed,
    output logic      [11:0]           serial_cfg,
    output logic      [17:0]           baud_div
);
    // ====================================================
    // reset release and plc pin synchronisers
    logic       rst_s1_r, rst_n;
    logic [2:0] plc_s1_r, plc_s2_r, plc_s3_r, plc_lvl_r, plc_lvl_d_r;
    logic [2:0] plc_rise;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // a level counts once the second and third stages agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            plc_s1_r    <= 3'h0;
            plc_s2_r    <= 3'h0;
            plc_s3_r    <= 3'h0;
            plc_lvl_r   <= 3'h0;
            plc_lvl_d_r <= 3'h0;
        end else begin
            plc_s1_r    <= plc_in;
            plc_s2_r    <= plc_s1_r;
            plc_s3_r    <= plc_s2_r;
            plc_lvl_r   <= (plc_s2_r & plc_s3_r) | (plc_lvl_r & (plc_s2_r | plc_s3_r));
            plc_lvl_d_r <= plc_lvl_r;
        end
    end
    assign plc_rise = plc_lvl_r & ~plc_lvl_d_r;

    // ====================================================
    // registers
    logic [2:0]             loc_r;
    logic [1:0]             mass_r;
    logic [2:0]             rec_func_r [REC_CH];
    logic [2:0]             scale_r;
    logic [3:0]             upper_r;
    logic [11:0]            serial_r;
    logic [RELAYS*4-1:0]    relay_func_r;
    logic                   reject_r, cal_adv_r;
    logic                   mass_wr, mass_ok;

    assign mass_wr = we && addr == io_ctrl_pkg::OFS_MASS;
    assign mass_ok = in_standby && wdata[1:0] != 2'h3;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loc_r        <= io_ctrl_pkg::LOC_RST;
            scale_r      <= io_ctrl_pkg::SCALE_RST;
            upper_r      <= io_ctrl_pkg::UPPER_RST;
            serial_r     <= io_ctrl_pkg::SERIAL_RST;
            relay_func_r <= io_ctrl_pkg::RELAY_RST;
        end else if (we) begin
            case (addr)
                io_ctrl_pkg::OFS_LOC: begin
                    if (wdata[2:0] <= io_ctrl_pkg::LOC_RST) begin
                        loc_r <= wdata[2:0];
                    end
                end
                io_ctrl_pkg::OFS_SCALE: begin
                    scale_r <= (wdata[2:0] > 3'h5) ? 3'h5 : wdata[2:0];
                    upper_r <= wdata[io_ctrl_pkg::UPPER_LSB +: 4];
                end
                io_ctrl_pkg::OFS_SERIAL: serial_r <= wdata[11:0];
                io_ctrl_pkg::OFS_RELAY:  relay_func_r <= wdata[RELAYS*4-1:0];
                default: ;
            endcase
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < REC_CH; gc++) begin : g_rec_reg
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    rec_func_r[gc] <= io_ctrl_pkg::REC_OFF;
                end else if (we && addr == io_ctrl_pkg::OFS_REC0 + 8'(gc * 4) && wdata[2:0] != 3'h7) begin
                    rec_func_r[gc] <= wdata[2:0];
                end
            end
        end
    endgenerate

    // mass changes outside standby are dropped and flagged
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mass_r    <= io_ctrl_pkg::MASS_RST;
            reject_r  <= 1'b0;
            cal_adv_r <= 1'b0;
        end else begin
            if (mass_wr && mass_ok) begin
                mass_r <= wdata[1:0];
            end
            // a new event wins over the write-one clear in the same cycle
            if (mass_wr && !mass_ok) begin
                reject_r <= 1'b1;
            end else if (we && addr == io_ctrl_pkg::OFS_STATUS && wdata[io_ctrl_pkg::ST_REJECT]) begin
                reject_r <= 1'b0;
            end
            // advisory only; nothing is blocked until software calibrates
            if (mass_wr && mass_ok && wdata[1:0] != mass_r) begin
                cal_adv_r <= 1'b1;
            end else if (cal_running || (we && addr == io_ctrl_pkg::OFS_STATUS && wdata[io_ctrl_pkg::ST_CAL_ADV])) begin
                cal_adv_r <= 1'b0;
            end
        end
    end

    // ====================================================
    // command arbitration
    logic keys_ok, plc_ok, ser_ok;
    assign keys_ok = loc_r == io_ctrl_pkg::LOC_LOCAL || loc_r == io_ctrl_pkg::LOC_LOCAL_PLC
                  || loc_r == io_ctrl_pkg::LOC_LOCAL_SERIAL;
    assign plc_ok  = loc_r == io_ctrl_pkg::LOC_PLC || loc_r == io_ctrl_pkg::LOC_LOCAL_PLC;
    assign ser_ok  = loc_r == io_ctrl_pkg::LOC_SERIAL || loc_r == io_ctrl_pkg::LOC_LOCAL_SERIAL;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_start <= 1'b0;
            cmd_stop  <= 1'b0;
            cmd_zero  <= 1'b0;
        end else begin
            cmd_start <= (keys_ok && (panel_start || remote_start)) || (plc_ok && plc_rise[0])
                      || (ser_ok && serial_start);
            cmd_stop  <= (keys_ok && (panel_stop || remote_stop)) || (plc_ok && plc_rise[1])
                      || (ser_ok && serial_stop);
            cmd_zero  <= (keys_ok && (panel_zero || remote_zero)) || (plc_ok && plc_rise[2])
                      || (ser_ok && serial_zero);
        end
    end

    // ====================================================
    // recorder encoding
    // per-mille log10 of the leading digit; finer digits are not interpolated
    function automatic int log_frac(input logic [9:0] mant);
        int d;
        d = int'(mant) / 100;
        case (d)
            1: log_frac = 0;
            2: log_frac = 301;
            3: log_frac = 477;
            4: log_frac = 602;
            5: log_frac = 699;
            6: log_frac = 778;
            7: log_frac = 845;
            8: log_frac = 903;
            9: log_frac = 954;
            default: log_frac = 0;
        endcase
    endfunction

    function automatic int clamp(input int v, input int lo);
        clamp = (v < lo) ? lo : (v > io_ctrl_pkg::MV_FULL) ? io_ctrl_pkg::MV_FULL : v;
    endfunction

    function automatic logic [13:0] rec_value(input logic [2:0] f, input logic [2:0] sc, input logic [3:0] up);
        int slope, gap, v;
        slope = 500;
        case (sc)
            3'h0: slope = 500;
            3'h1: slope = 1000;
            3'h2: slope = 2000;
            3'h3: slope = 2500;
            3'h4: slope = 5000;
            default: slope = 10000;
        endcase
        gap = int'($signed(up)) - int'(lr_exp);
        case (f)
            io_ctrl_pkg::REC_INLET: v = int'(inlet_pressure);
            io_ctrl_pkg::REC_FORE:  v = int'(forevacuum_pressure);
            io_ctrl_pkg::REC_MANT:  v = clamp(int'(lr_mant) * 10, io_ctrl_pkg::MV_ONE);
            io_ctrl_pkg::REC_EXP:   v = clamp(io_ctrl_pkg::MV_ONE + (int'(lr_exp) - io_ctrl_pkg::EXP_BASE)
                                        * io_ctrl_pkg::MV_EXP_STP, io_ctrl_pkg::MV_ONE);
            io_ctrl_pkg::REC_LIN: begin
                // full scale is the upper decade limit
                if (gap <= 0) begin
                    v = io_ctrl_pkg::MV_FULL;
                end else if (gap == 1) begin
                    v = int'(lr_mant) * 10;
                end else if (gap == 2) begin
                    v = int'(lr_mant);
                end else if (gap == 3) begin
                    v = int'(lr_mant) / 10;
                end else begin
                    v = 0;
                end
                v = clamp(v, 0);
            end
            io_ctrl_pkg::REC_LOG:   v = clamp(io_ctrl_pkg::MV_FULL - ((gap * 1000 - log_frac(lr_mant)) * slope) / 1000,
                                        io_ctrl_pkg::MV_ONE);
            default:                v = 0;
        endcase
        rec_value = 14'(v);
    endfunction

    logic lr_on_rec;
    always_comb begin
        lr_on_rec = 1'b0;
        for (int i = 0; i < REC_CH; i++) begin
            if (rec_func_r[i] >= io_ctrl_pkg::REC_MANT) begin
                lr_on_rec = 1'b1;
            end
        end
    end

    generate
        for (gc = 0; gc < REC_CH; gc++) begin : g_rec_out
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    rec_mv[gc*14 +: 14] <= 14'h0;
                end else begin
                    rec_mv[gc*14 +: 14] <= rec_value(rec_func_r[gc], scale_r, upper_r);
                end
            end
        end
    endgenerate

    // ====================================================
    // relay mapping, true means contact closed
    function automatic logic relay_state(input logic [3:0] f);
        case (f)
            io_ctrl_pkg::RLY_TRIG1:   relay_state = measuring && !trig_exceeded[0];
            io_ctrl_pkg::RLY_TRIG2:   relay_state = measuring && !trig_exceeded[1];
            io_ctrl_pkg::RLY_TRIG3:   relay_state = measuring && !trig_exceeded[2];
            io_ctrl_pkg::RLY_ZERO:    relay_state = zero_running;
            io_ctrl_pkg::RLY_READY:   relay_state = emission_on && !error_shown;
            io_ctrl_pkg::RLY_CAL_ACT: relay_state = cal_running;
            io_ctrl_pkg::RLY_CAL_REQ: relay_state = !cal_requested;
            io_ctrl_pkg::RLY_FAIL:    relay_state = !error_shown;
            io_ctrl_pkg::RLY_WARN:    relay_state = !warning_shown;
            io_ctrl_pkg::RLY_GAS:     relay_state = gas_ballast_on;
            io_ctrl_pkg::RLY_CLOSE:   relay_state = 1'b1;
            io_ctrl_pkg::RLY_STROBE:  relay_state = lr_on_rec && !lr_valid;
            default:                  relay_state = 1'b0;
        endcase
    endfunction

    generate
        for (gc = 0; gc < RELAYS; gc++) begin : g_relay
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    relay_closed[gc] <= 1'b0;
                end else begin
                    relay_closed[gc] <= relay_state(relay_func_r[gc*4 +: 4]);
                end
            end
        end
    endgenerate

    // ====================================================
    // serial configuration and register reads
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mass_sel   <= io_ctrl_pkg::MASS_RST;
            serial_cfg <= io_ctrl_pkg::SERIAL_RST;
            baud_div   <= 18'(io_ctrl_pkg::CLK_HZ / 9600);
            rdata      <= 32'h0;
        end else begin
            mass_sel   <= mass_r;
            serial_cfg <= serial_r;
            case (serial_r[io_ctrl_pkg::SER_BAUD_LSB +: 3])
                3'h0:    baud_div <= 18'(io_ctrl_pkg::CLK_HZ / 1200);
                3'h1:    baud_div <= 18'(io_ctrl_pkg::CLK_HZ / 2400);
                3'h2:    baud_div <= 18'(io_ctrl_pkg::CLK_HZ / 4800);
                3'h3:    baud_div <= 18'(io_ctrl_pkg::CLK_HZ / 9600);
                default: baud_div <= 18'(io_ctrl_pkg::CLK_HZ / 19200);
            endcase
            rdata <= 32'h0;
            if (re) begin
                case (addr)
                    io_ctrl_pkg::OFS_LOC:    rdata <= {29'h0, loc_r};
                    io_ctrl_pkg::OFS_MASS:   rdata <= {30'h0, mass_r};
                    io_ctrl_pkg::OFS_REC0:   rdata <= {29'h0, rec_func_r[0]};
                    io_ctrl_pkg::OFS_REC1:   rdata <= {29'h0, rec_func_r[REC_CH-1]};
                    io_ctrl_pkg::OFS_SCALE:  rdata <= {20'h0, upper_r, 5'h0, scale_r};
                    io_ctrl_pkg::OFS_SERIAL: rdata <= {20'h0, serial_r};
                    io_ctrl_pkg::OFS_RELAY:  rdata <= 32'(relay_func_r);
                    io_ctrl_pkg::OFS_STATUS: rdata <= {26'h0, cal_adv_r, reject_r, 4'(relay_closed)};
                    default:                 rdata <= 32'h0;
                endcase
            end
        end
    end

    // ====================================================
    // assertions
    sequence s_mass_write_ok;
        mass_wr && mass_ok;
    endsequence

    a_plc_locks_keys: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loc_r == io_ctrl_pkg::LOC_PLC && !plc_rise[0] |=> !cmd_start)
        else $error("key start accepted in plc-only location");
    a_serial_locks_keys: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loc_r == io_ctrl_pkg::LOC_SERIAL && (panel_zero || remote_zero) && !serial_zero |=> !cmd_zero)
        else $error("key zero accepted in serial-only location");
    a_local_plc_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loc_r == io_ctrl_pkg::LOC_LOCAL_PLC && (panel_stop || plc_rise[1]) |=> cmd_stop)
        else $error("stop lost in local plus plc location");
    a_local_keys_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loc_r == io_ctrl_pkg::LOC_LOCAL && remote_start |=> cmd_start)
        else $error("remote start lost in local location");
    a_plc_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !plc_ok && !keys_ok && !serial_zero |=> !cmd_zero)
        else $error("plc zero accepted outside plc locations");
    a_mass_accept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_mass_write_ok ##1 1'b1 |=> mass_sel == $past(wdata[1:0], 2))
        else $error("standby mass change not applied");
    a_mass_reject: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mass_wr && !in_standby |=> $stable(mass_r) && reject_r)
        else $error("mass changed outside standby");
    a_rec_exponent: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rec_func_r[0] == io_ctrl_pkg::REC_EXP && lr_exp == -6'sd10 |=> rec_mv[13:0] == 14'h7d0)
        else $error("exponent staircase wrong");
    a_trig_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
        relay_func_r[3:0] == io_ctrl_pkg::RLY_TRIG1 && (trig_exceeded[0] || !measuring) |=> !relay_closed[0])
        else $error("trigger relay closed while exceeded");
    a_fixed_relay: assert property (@(posedge ref_clk) disable iff (!rst_n)
        relay_func_r[7:4] == io_ctrl_pkg::RLY_CLOSE [*2] |-> relay_closed[1])
        else $error("fixed-closed relay not closed");
endmodule
`default_nettype wire

// [verif/leak_detector_io_control_tb_top.sv]
// self-checking bench for the i/o control block
// assumes the plc model on the pins and one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module leak_detector_io_control_tb_top;
    logic        ref_clk, rstn, we, re, in_standby;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [2:0]  pnl, rmt, ser, req, plc_in, cmd;
    logic [11:0] st;
    logic [13:0] inl, fore;
    logic [9:0]  mant;
    logic [5:0]  ex;
    logic [1:0]  mass_sel;
    logic [27:0] rec_mv;
    logic [3:0]  relay_closed;
    logic [11:0] scfg;
    logic [17:0] bdiv;
    int          num_errors, comparisons, cyc, n_start, i, k;

    leak_detector_io_control dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .panel_start(pnl[0]), .panel_stop(pnl[1]), .panel_zero(pnl[2]), .remote_start(rmt[0]),
        .remote_stop(rmt[1]), .remote_zero(rmt[2]), .serial_start(ser[0]), .serial_stop(ser[1]),
        .serial_zero(ser[2]), .plc_in(plc_in), .cmd_start(cmd[0]), .cmd_stop(cmd[1]), .cmd_zero(cmd[2]),
        .in_standby(in_standby), .measuring(st[0]), .trig_exceeded(st[3:1]), .zero_running(st[4]),
        .emission_on(st[5]), .error_shown(st[6]), .warning_shown(st[7]), .cal_running(st[8]),
        .cal_requested(st[9]), .gas_ballast_on(st[10]), .inlet_pressure(inl), .forevacuum_pressure(fore),
        .lr_mant(mant), .lr_exp(ex), .lr_valid(st[11]), .mass_sel(mass_sel), .rec_mv(rec_mv),
        .relay_closed(relay_closed), .serial_cfg(scfg), .baud_div(bdiv));
    plc_model plc (.ref_clk(ref_clk), .req(req), .plc_in(plc_in));

    // ==========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge ref_clk);
        we <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge ref_clk);
        re <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // keys pass in locations 2..4, the serial link in 1 and 3
    function automatic logic acc(input int s, input int loc);
        return (s == 2) ? (loc == 1 || loc == 3) : (loc >= 2);
    endfunction
    task automatic pulse(input int s, input int loc);
        logic [2:0] c;
        c = 3'($urandom_range(1, 7));
        @(posedge ref_clk);
        if (s == 0) pnl <= c;
        else if (s == 1) rmt <= c;
        else ser <= c;
        @(posedge ref_clk);
        {pnl, rmt, ser} <= '0;
        #1 chk(cmd, acc(s, loc) ? c : 3'h0);
    endtask
    function automatic logic [13:0] rec_exp(input int f);
        case (f)
            1: return inl;
            2: return fore;
            3: return 14'(mant * 10);
            default: return 14'(1000 + ($signed(ex) + 12) * 500);
        endcase
    endfunction
    function automatic logic rly_exp(input int f);
        case (f)
            0, 1, 2: return st[0] & ~st[f+1];
            3: return st[4];
            4: return st[5] & ~st[6];
            5: return st[8];
            6: return ~st[9];
            7: return ~st[6];
            8: return ~st[7];
            9: return st[10];
            11: return 1'b1;
            12: return ~st[11];
            default: return 1'b0;
        endcase
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // a hang ends the run as a mismatch
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cmd[0] === 1'b1) n_start <= n_start + 1;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    // ==========
    // tests
    initial begin
        {rstn, we, re, addr, wdata, pnl, rmt, ser, req, st, in_standby, inl, fore, mant, ex} = '0;
        {num_errors, comparisons, cyc, n_start} = '0;
        k = $urandom(54);
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(mass_sel, io_ctrl_pkg::MASS_HE4);
        chk(relay_closed, 4'h2);
        $display("reset test done");
        for (i = 4; i >= 0; i--) begin
            wr(io_ctrl_pkg::OFS_LOC, i);
            for (k = 0; k < 3; k++) pulse(k, i);
            @(posedge ref_clk);
            req <= 3'h1;
            @(posedge ref_clk);
            req <= 3'h0;
            k = n_start;
            repeat (16) @(posedge ref_clk);
            chk(n_start - k, (i == 0 || i == 2) ? 1 : 0);
        end
        $display("location test done");
        wr(io_ctrl_pkg::OFS_MASS, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(mass_sel, 32'h2);
        in_standby <= 1'b1;
        for (i = 0; i < 3; i++) begin
            wr(io_ctrl_pkg::OFS_MASS, i);
            repeat (2) @(posedge ref_clk);
            chk(mass_sel, i);
        end
        rd(io_ctrl_pkg::OFS_STATUS, 32'h32);
        // the far side recalibrates after the mass change, which clears the advice
        @(posedge ref_clk);
        st <= 12'h100;
        @(posedge ref_clk);
        st <= 12'h0;
        rd(io_ctrl_pkg::OFS_STATUS, 32'h12);
        wr(io_ctrl_pkg::OFS_SERIAL, 32'h5e1);
        repeat (2) @(posedge ref_clk);
        #1 chk({bdiv, scfg}, {18'd83333, 12'h5e1});
        rd(io_ctrl_pkg::OFS_SERIAL, 32'h5e1);
        $display("mass test done");
        for (i = 1; i < 5; i++) begin
            wr(io_ctrl_pkg::OFS_REC0, i);
            wr(io_ctrl_pkg::OFS_REC1, i);
            inl  <= 14'($urandom_range(0, 10000));
            fore <= 14'($urandom_range(0, 10000));
            mant <= 10'($urandom_range(100, 999));
            // corner case: exponent -10 in the last pass
            ex   <= (i == 4) ? 6'h36 : 6'($urandom_range(0, 18) - 12);
            repeat (3) @(posedge ref_clk);
            #1 chk(rec_mv, {2{rec_exp(i)}});
        end
        $display("recorder test done");
        wr(io_ctrl_pkg::OFS_REC0, 32'h3);
        for (i = 0; i < 16; i++) begin
            wr(io_ctrl_pkg::OFS_RELAY, {4{4'(i)}});
            for (k = 0; k < 4; k++) begin
                @(posedge ref_clk);
                st <= 12'($urandom());
                repeat (3) @(posedge ref_clk);
                #1 chk(relay_closed, {4{rly_exp(i)}});
            end
        end
        $display("relay test done");
        complete_run();
    end
endmodule
`default_nettype wire

// [verif/plc_model.sv]
// external plc that drives the three digital input pins
// assumes requests are one-cycle pulses in the ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module plc_model (
    // clock and request
    input  wire logic       ref_clk,
    input  wire logic [2:0] req,
    // pins
    output logic      [2:0] plc_in
);
    logic [3:0] hold_r = 4'h0;
    initial plc_in = 3'h0;
    // a pin level is held for 8 cycles so that it outlasts the input synchroniser
    always @(posedge ref_clk) begin
        if (req != 3'h0) begin
            plc_in <= req;
            hold_r <= 4'h8;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
            if (hold_r == 4'h1) plc_in <= 3'h0;
        end
    end
endmodule
`default_nettype wire
